// [verilog/pci_top.sv]
// module: pin change detector with apb register file, interrupt and wake request
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
// ****************************************
// How it works
// - every pin of the first three ports and pin 3 of the fifth port have change detection, no other pin.
// - each capable pin is enabled on its own, in any combination, as an interrupt source.
// - a one in a pin's rise enable bit arms its rising edge detector.
// - a one in a pin's fall enable bit arms its falling edge detector.
// - with both enable bits set, edges of either polarity are detected.
// - an armed edge sets the pin's sticky change flag, which holds until software clears it.
// - edges are detected and flags set even while the master enable is clear; only the request and the wake request are held off.
// - the summary flag is the or of all per-pin change flags and is read only.
// - the change interrupt request is high only when summary flag and master enable are both set.
// - writing zero to a flag bit clears that flag.
// - an armed edge in the same cycle as a clearing write leaves the flag set.
// - a detected armed edge wakes the core from sleep when the master enable is set.
// - during sleep the flags are updated before the wake request reaches the core.
// ****************************************
module pci_top #(
    parameter int SYNC_STAGES = pci_pkg::SYNC_STAGES
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [7:0]            first_port,
    input  wire logic [7:0]            second_port,
    input  wire logic [7:0]            third_port,
    input  wire logic                  fifth_port_pin3,
    input  wire logic                  sleep_mode,
    output logic                       peripheral_irq_request_0,
    output logic                       change_summary_flag,
    output logic                       wake_request,
    output logic                       block_irq
);

    // ****************************************
    // elaboration check
    // ****************************************
    if (SYNC_STAGES < 2) begin : g_bad_param
        $error("pci_top needs at least two synchroniser stages");
    end

    // ****************************************
    // declarations
    // ****************************************
    localparam int NP = pci_pkg::NUM_PINS;
    localparam int NQ = pci_pkg::NUM_PORTS;

    logic [NP-1:0] pin_raw;
    logic [NP-1:0] pin_now;
    logic [NP-1:0] pin_prev;
    logic [NP-1:0] rise_seen;
    logic [NP-1:0] fall_seen;
    logic [NP-1:0] armed_edge;
    logic [NP-1:0] rise_detect_enable_q;
    logic [NP-1:0] rise_detect_enable_d;
    logic [NP-1:0] fall_detect_enable_q;
    logic [NP-1:0] fall_detect_enable_d;
    logic [NP-1:0] pin_change_flags_q;
    logic [NP-1:0] pin_change_flags_d;
    logic          change_irq_master_enable_q;
    logic          change_irq_master_enable_d;
    logic [NQ-1:0] irq_status_q;
    logic [NQ-1:0] irq_status_d;
    logic [NQ-1:0] irq_mask_q;
    logic [NQ-1:0] irq_mask_d;
    logic [NQ-1:0] port_event;
    logic [31:0]   prdata_d;
    logic          pready_d;
    logic          pslverr_d;
    logic          summary_d;

    // ****************************************
    // pin capture and edge detection
    // ****************************************
    // only the capable pins are wired in; nothing else can reach a flag
    assign pin_raw = {fifth_port_pin3, third_port, second_port, first_port};

    pci_sync #(
        .WIDTH  (NP),
        .STAGES (SYNC_STAGES)
    ) u_sync (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin_raw    (pin_raw),
        .pin_now_q  (pin_now),
        .pin_prev_q (pin_prev)
    );

    assign rise_seen  = pin_now & ~pin_prev & rise_detect_enable_q;
    assign fall_seen  = ~pin_now & pin_prev & fall_detect_enable_q;
    assign armed_edge = rise_seen | fall_seen;

    // ****************************************
    // apb decode
    // ****************************************
    // setup cycle loads the answer; the access phase always lasts one cycle
    wire        setup_phase = psel & ~penable;
    wire        access_done = psel & penable & pready;
    wire        wr_access   = access_done & pwrite;
    wire        rd_access   = access_done & ~pwrite;
    wire        word_ok     = (paddr[1:0] == 2'b00);

    wire        sel_ctrl    = word_ok & (paddr == pci_pkg::CTRL_OFFSET);
    wire        sel_summary = word_ok & (paddr == pci_pkg::SUMMARY_OFFSET);
    wire        sel_status  = word_ok & (paddr == pci_pkg::IRQ_STATUS_OFFSET);
    wire        sel_mask    = word_ok & (paddr == pci_pkg::IRQ_MASK_OFFSET);

    wire [11:0] rise_rel    = paddr - pci_pkg::RISE_BASE_OFFSET;
    wire [11:0] fall_rel    = paddr - pci_pkg::FALL_BASE_OFFSET;
    wire [11:0] flag_rel    = paddr - pci_pkg::FLAG_BASE_OFFSET;
    wire        sel_rise    = word_ok & (paddr >= pci_pkg::RISE_BASE_OFFSET) & (rise_rel[11:4] == 8'h00);
    wire        sel_fall    = word_ok & (paddr >= pci_pkg::FALL_BASE_OFFSET) & (fall_rel[11:4] == 8'h00);
    wire        sel_flag    = word_ok & (paddr >= pci_pkg::FLAG_BASE_OFFSET) & (flag_rel[11:4] == 8'h00);
    wire [1:0]  port_idx    = paddr[3:2];

    wire        sel_any     = sel_ctrl | sel_summary | sel_status | sel_mask | sel_rise | sel_fall | sel_flag;

    // ****************************************
    // per-port register views
    // ****************************************
    logic [7:0] rise_view [NQ];
    logic [7:0] fall_view [NQ];
    logic [7:0] flag_view [NQ];

    for (genvar p = 0; p < NQ - 1; p++) begin : g_view
        assign rise_view[p] = rise_detect_enable_q[p*8 +: 8];
        assign fall_view[p] = fall_detect_enable_q[p*8 +: 8];
        assign flag_view[p] = pin_change_flags_q[p*8 +: 8];
    end
    // fifth port holds one pin at its own bit position, rest read as zero
    assign rise_view[NQ-1] = {4'h0, rise_detect_enable_q[NP-1], 3'h0};
    assign fall_view[NQ-1] = {4'h0, fall_detect_enable_q[NP-1], 3'h0};
    assign flag_view[NQ-1] = {4'h0, pin_change_flags_q[NP-1], 3'h0};

    // ****************************************
    // read data
    // ****************************************
    wire [31:0] rd_ctrl    = {31'h0000_0000, change_irq_master_enable_q};
    wire [31:0] rd_summary = {31'h0000_0000, change_summary_flag};
    wire [31:0] rd_status  = {28'h000_0000, irq_status_q};
    wire [31:0] rd_mask    = {28'h000_0000, irq_mask_q};
    wire [31:0] rd_rise    = {24'h00_0000, rise_view[port_idx]};
    wire [31:0] rd_fall    = {24'h00_0000, fall_view[port_idx]};
    wire [31:0] rd_flag    = {24'h00_0000, flag_view[port_idx]};

    wire [31:0] rd_mux = sel_ctrl    ? rd_ctrl    :
                         sel_summary ? rd_summary :
                         sel_status  ? rd_status  :
                         sel_mask    ? rd_mask    :
                         sel_rise    ? rd_rise    :
                         sel_fall    ? rd_fall    :
                         sel_flag    ? rd_flag    :
                         pci_pkg::DATA_RESET;

    assign prdata_d  = setup_phase ? rd_mux : prdata;
    assign pready_d  = setup_phase;
    assign pslverr_d = setup_phase & ~sel_any;

    // ****************************************
    // control writes
    // ****************************************
    wire wr_ctrl = wr_access & sel_ctrl & ~pslverr;
    wire wr_mask = wr_access & sel_mask & ~pslverr;

    assign change_irq_master_enable_d = wr_ctrl ? pwdata[pci_pkg::CTRL_MASTER_EN_BIT]
                                                : change_irq_master_enable_q;
    assign irq_mask_d = wr_mask ? pwdata[NQ-1:0] : irq_mask_q;

    // ****************************************
    // per-pin enables and sticky flags
    // ****************************************
    for (genvar i = 0; i < NP; i++) begin : g_pin
        localparam int          PORT = (i < 24) ? (i / 8) : 3;
        localparam int          BITP = (i < 24) ? (i % 8) : pci_pkg::E_PIN_BIT;
        localparam logic [1:0]  PIDX = 2'(PORT);

        wire hit_port = (port_idx == PIDX);
        wire wr_rise  = wr_access & sel_rise & hit_port;
        wire wr_fall  = wr_access & sel_fall & hit_port;
        wire wr_flag  = wr_access & sel_flag & hit_port;
        wire clr_flag = wr_flag & ~pwdata[BITP];

        assign rise_detect_enable_d[i] = wr_rise ? pwdata[BITP] : rise_detect_enable_q[i];
        assign fall_detect_enable_d[i] = wr_fall ? pwdata[BITP] : fall_detect_enable_q[i];
        // set beats clear so an edge during the clearing write survives
        assign pin_change_flags_d[i] = (pin_change_flags_q[i] & ~clr_flag) | armed_edge[i];
    end

    // ****************************************
    // summary, request and wake
    // ****************************************
    // detection is independent of the master enable; only the request and the wake request are gated
    assign summary_d = |pin_change_flags_d;

    // ****************************************
    // block interrupt status
    // ****************************************
    for (genvar p = 0; p < NQ - 1; p++) begin : g_event
        assign port_event[p] = |armed_edge[p*8 +: 8];
    end
    assign port_event[NQ-1] = armed_edge[NP-1];

    // read clears only bits already reported, so a fresh event wins
    wire [NQ-1:0] status_clr = (rd_access & sel_status) ? prdata[NQ-1:0] : pci_pkg::IRQ_VEC_RESET;
    assign irq_status_d = (irq_status_q & ~status_clr) | port_event;

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise_detect_enable_q       <= pci_pkg::PIN_VEC_RESET;
            fall_detect_enable_q       <= pci_pkg::PIN_VEC_RESET;
            pin_change_flags_q         <= pci_pkg::PIN_VEC_RESET;
            change_irq_master_enable_q <= pci_pkg::BIT_RESET;
            irq_status_q               <= pci_pkg::IRQ_VEC_RESET;
            irq_mask_q                 <= pci_pkg::IRQ_VEC_RESET;
        end else begin
            rise_detect_enable_q       <= rise_detect_enable_d;
            fall_detect_enable_q       <= fall_detect_enable_d;
            pin_change_flags_q         <= pin_change_flags_d;
            change_irq_master_enable_q <= change_irq_master_enable_d;
            irq_status_q               <= irq_status_d;
            irq_mask_q                 <= irq_mask_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= pci_pkg::DATA_RESET;
            pready  <= pci_pkg::BIT_RESET;
            pslverr <= pci_pkg::BIT_RESET;
        end else begin
            prdata  <= prdata_d;
            pready  <= pready_d;
            pslverr <= pslverr_d;
        end
    end

    // outputs get flops of their own, which alone would leave them one cycle behind the flags,
    // but all but wake_request are fed from next-state so they line up with the flag registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            change_summary_flag      <= pci_pkg::BIT_RESET;
            peripheral_irq_request_0 <= pci_pkg::BIT_RESET;
            wake_request             <= pci_pkg::BIT_RESET;
            block_irq                <= pci_pkg::BIT_RESET;
        end else begin
            change_summary_flag      <= summary_d;
            peripheral_irq_request_0 <= summary_d & change_irq_master_enable_d;
            // wake is taken from the stored flags, so flags are visible first
            wake_request             <= sleep_mode & change_summary_flag
                                        & change_irq_master_enable_q;
            block_irq                <= |(irq_status_d & irq_mask_d);
        end
    end

endmodule

// [include/pci_pkg.sv]
// package: register map, pin layout and reset values of the pin change detector
package pci_pkg;

    // ****************************************
    // pin layout
    // ****************************************
    localparam int PORT_WIDTH   = 8;
    localparam int NUM_PORTS    = 4;
    localparam int NUM_PINS     = 25;
    localparam int E_PIN_BIT    = 3;
    localparam int SYNC_STAGES  = 2;

    // ****************************************
    // register offsets (byte addresses)
    // ****************************************
    localparam logic [11:0] CTRL_OFFSET       = 12'h000;
    localparam logic [11:0] SUMMARY_OFFSET    = 12'h004;
    localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h008;
    localparam logic [11:0] IRQ_MASK_OFFSET   = 12'h00C;
    localparam logic [11:0] RISE_BASE_OFFSET  = 12'h010;
    localparam logic [11:0] FALL_BASE_OFFSET  = 12'h020;
    localparam logic [11:0] FLAG_BASE_OFFSET  = 12'h030;
    localparam logic [11:0] PORT_STRIDE       = 12'h004;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CTRL_MASTER_EN_BIT = 0;
    localparam int SUMMARY_FLAG_BIT   = 0;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [NUM_PINS-1:0]  PIN_VEC_RESET  = 25'h000_0000;
    localparam logic [NUM_PORTS-1:0] IRQ_VEC_RESET  = 4'h0;
    localparam logic                 BIT_RESET      = 1'b0;
    localparam logic [31:0]          DATA_RESET     = 32'h0000_0000;

endpackage

// [verilog/pci_sync.sv]
// module: pin synchroniser with previous-value stage for edge compare
`timescale 1ns/1ps
module pci_sync #(
    parameter int WIDTH  = 25,
    parameter int STAGES = 2
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] pin_raw,
    output logic      [WIDTH-1:0] pin_now_q,
    output logic      [WIDTH-1:0] pin_prev_q
);

    // ****************************************
    // elaboration check
    // ****************************************
    if (STAGES < 2 || WIDTH < 1) begin : g_bad_param
        $error("pci_sync needs at least two stages and one pin");
    end

    // ****************************************
    // synchroniser chain
    // ****************************************
    // first stage feeds only the next stage; metastability stays contained
    logic [WIDTH-1:0] chain_q [STAGES];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int s = 0; s < STAGES; s++) begin
                chain_q[s] <= '0;
            end
            pin_prev_q <= '0;
        end else begin
            chain_q[0] <= pin_raw;
            for (int s = 1; s < STAGES; s++) begin
                chain_q[s] <= chain_q[s-1];
            end
            pin_prev_q <= chain_q[STAGES-1];
        end
    end

    assign pin_now_q = chain_q[STAGES-1];

endmodule

// [testbench/pci_top_properties.sv]
// checker: handshake, flag, request and wake properties at the detector ports
`timescale 1ns/1ps
module pci_top_properties #(
    parameter int SYNC_STAGES = 2
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sleep_mode,
    input wire logic        peripheral_irq_request_0,
    input wire logic        change_summary_flag,
    input wire logic        wake_request
);
    // ********
    // shadow of the master enable, from completed writes only
    // ********
    logic en_q;
    logic en_d;
    logic all_q;
    wire  acc_wr  = psel && penable && pready && pwrite && !pslverr;
    wire  wr_flag = acc_wr && (paddr[11:4] == 8'h03);
    wire  all_now = sleep_mode && change_summary_flag && en_q;
    assign en_d = (acc_wr && paddr == pci_pkg::CTRL_OFFSET) ? pwdata[0] : en_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q  <= 1'b0;
            all_q <= 1'b0;
        end else begin
            en_q  <= en_d;
            all_q <= all_now;
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ********
    // properties
    // ********
    property p_pready_answer;
        psel && !penable |=> pready;
    endproperty
    a_pready_answer: assert property (p_pready_answer) else $error("no pready after setup");
    property p_pready_single;
        pready |=> !pready;
    endproperty
    a_pready_single: assert property (p_pready_single) else $error("pready longer than one cycle");
    property p_slverr_with_pready;
        pslverr |-> pready;
    endproperty
    a_slverr_with_pready: assert property (p_slverr_with_pready) else $error("pslverr without pready");
    property p_prdata_hold;
        !$past(psel && !penable) |-> $stable(prdata);
    endproperty
    a_prdata_hold: assert property (p_prdata_hold) else $error("prdata moved outside setup");
    property p_flag_sticky;
        change_summary_flag && !wr_flag |=> change_summary_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without write");
    property p_irq_masked;
        !en_q && !$past(en_q) |-> !peripheral_irq_request_0;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("request with master off");
    property p_irq_raise;
        en_q && $past(en_q) && change_summary_flag && $past(change_summary_flag) |-> peripheral_irq_request_0;
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("request missing");
    property p_wake;
        all_now && all_q |-> wake_request;
    endproperty
    a_wake: assert property (p_wake) else $error("wake missing in sleep");
endmodule

bind pci_top pci_top_properties #(.SYNC_STAGES(SYNC_STAGES)) i_chk (.*);

// [testbench/pci_pin_model.sv]
// model: outside world driving the monitored port pins
`timescale 1ns/1ps
module pci_pin_model (
    input  wire logic [24:0] pin_lvl,
    output wire logic [7:0]  first_port,
    output wire logic [7:0]  second_port,
    output wire logic [7:0]  third_port,
    output wire logic        fifth_port_pin3
);
    // ********
    // pin drivers
    // ********
    // levels move right after a rising edge, as the bench sets them
    assign first_port      = pin_lvl[7:0];
    assign second_port     = pin_lvl[15:8];
    assign third_port      = pin_lvl[23:16];
    assign fifth_port_pin3 = pin_lvl[24];
endmodule

// [testbench/pci_top_test.sv]
// testbench: table-driven and directed checks of the pin change detector
`timescale 1ns/1ps
module pci_top_test;
    typedef struct packed {
        logic [1:0] port;
        logic [7:0] rise;
        logic [7:0] fall;
        logic [7:0] lv0;
        logic [7:0] lv1;
        logic [7:0] flag;
    } pci_row_type;
    localparam pci_row_type ROWS [7] = '{
        '{2'h0, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff}, '{2'h0, 8'hff, 8'h00, 8'hff, 8'h00, 8'h00},
        '{2'h1, 8'h00, 8'h0f, 8'hff, 8'h00, 8'h0f}, '{2'h2, 8'ha5, 8'h5a, 8'h0f, 8'hf0, 8'haa},
        '{2'h3, 8'h08, 8'h08, 8'h00, 8'h08, 8'h08}, '{2'h3, 8'hff, 8'hff, 8'h08, 8'h00, 8'h08},
        '{2'h1, 8'hff, 8'hff, 8'h3c, 8'hc3, 8'hff}};
    localparam int DLY [3] = '{0, 1, 6};
    localparam logic [11:0] FLG = pci_pkg::FLAG_BASE_OFFSET;
    localparam logic [11:0] RST_ADDR [4] = '{pci_pkg::CTRL_OFFSET, pci_pkg::IRQ_MASK_OFFSET,
        pci_pkg::RISE_BASE_OFFSET, FLG};
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  port_a;
    logic [7:0]  port_b;
    logic [7:0]  port_c;
    logic        port_e3;
    logic        sleep_mode;
    logic        irq;
    logic        summary;
    logic        wake;
    logic        block_irq;
    logic [24:0] pin_lvl;
    logic [31:0] rd;
    logic        slv;
    int          mismatches = 0;
    int          n_tests    = 0;
    int          cycles     = 0;

    pci_pin_model i_pins (.pin_lvl(pin_lvl), .first_port(port_a), .second_port(port_b),
        .third_port(port_c), .fifth_port_pin3(port_e3));
    pci_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .first_port(port_a), .second_port(port_b), .third_port(port_c), .fifth_port_pin3(port_e3),
        .sleep_mode(sleep_mode), .peripheral_irq_request_0(irq), .change_summary_flag(summary),
        .wake_request(wake), .block_irq(block_irq));

    // ********
    // helpers
    // ********
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            results();
        end
    end
    function automatic logic [11:0] at(input logic [11:0] base, input logic [1:0] p);
        return base + {8'h00, p, 2'h0};
    endfunction
    // request held until pready is seen high; one idle edge after keeps strobes single-driven
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        slv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic set_port(input logic [1:0] p, input logic [7:0] v);
        if (p == 2'h3) begin
            pin_lvl[24] <= v[3];
        end else begin
            pin_lvl[p*8 +: 8] <= v;
        end
    endtask
    task automatic results;
        $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ********
    // sequence
    // ********
    initial begin
        pci_row_type r;
        int          n;
        {presetn, psel, penable, pwrite, sleep_mode} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pin_lvl = 25'h000_0000;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // master enable stays clear through the table
        foreach (ROWS[i]) begin
            r = ROWS[i];
            set_port(r.port, r.lv0);
            apb(1'b1, at(pci_pkg::RISE_BASE_OFFSET, r.port), {24'h00_0000, r.rise});
            apb(1'b1, at(pci_pkg::FALL_BASE_OFFSET, r.port), {24'h00_0000, r.fall});
            repeat (5) @(posedge pclk);
            for (int p = 0; p < 4; p++) begin
                apb(1'b1, at(FLG, 2'(p)), 32'h0000_0000);
            end
            set_port(r.port, r.lv1);
            repeat (5) @(posedge pclk);
            apb(1'b0, at(FLG, r.port), 32'h0000_0000);
            chk(rd, {24'h00_0000, r.flag});
            chk({30'h0000_0000, summary, irq}, {30'h0000_0000, r.flag != 8'h00, 1'b0});
        end
        // clearing write racing a fresh edge on pin 0
        apb(1'b1, pci_pkg::FALL_BASE_OFFSET, 32'h0000_00ff);
        foreach (DLY[k]) begin
            apb(1'b1, FLG, 32'h0000_0000);
            pin_lvl[0] <= ~pin_lvl[0];
            repeat (DLY[k]) @(posedge pclk);
            apb(1'b1, FLG, 32'h0000_0000);
            repeat (5) @(posedge pclk);
            apb(1'b0, FLG, 32'h0000_0000);
            chk(rd, 32'(DLY[k] < 2));
        end
        pin_lvl[2:1] <= ~pin_lvl[2:1];
        repeat (5) @(posedge pclk);
        apb(1'b0, FLG, 32'h0000_0000);
        chk(rd, 32'h0000_0006);
        pin_lvl[3] <= ~pin_lvl[3];
        apb(1'b1, FLG, {24'h00_0000, rd[7:0] ^ 8'hff});
        repeat (5) @(posedge pclk);
        apb(1'b0, FLG, 32'h0000_0000);
        chk(rd, 32'h0000_0008);
        // edge during sleep with master enable set; table rows left flags on other ports
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, at(FLG, 2'(p)), 32'h0000_0000);
        end
        apb(1'b1, pci_pkg::CTRL_OFFSET, 32'h0000_0001);
        sleep_mode <= 1'b1;
        repeat (2) @(posedge pclk);
        chk({30'h0000_0000, wake, irq}, 32'h0000_0000);
        pin_lvl[5] <= ~pin_lvl[5];
        n = 0;
        while (wake !== 1'b1 && n < 10) begin
            @(posedge pclk);
            n++;
        end
        chk({29'h0000_0000, wake, summary, irq}, 32'h0000_0007);
        sleep_mode <= 1'b0;
        apb(1'b0, FLG, 32'h0000_0000);
        chk(rd, 32'h0000_0020);
        apb(1'b1, pci_pkg::CTRL_OFFSET, 32'h0000_0000);
        repeat (2) @(posedge pclk);
        chk({30'h0000_0000, summary, irq}, 32'h0000_0002);
        // port events: read-to-clear status and mask
        apb(1'b0, pci_pkg::IRQ_STATUS_OFFSET, 32'h0000_0000);
        chk(rd, 32'h0000_000f);
        apb(1'b0, pci_pkg::IRQ_STATUS_OFFSET, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b1, pci_pkg::IRQ_MASK_OFFSET, 32'h0000_0002);
        pin_lvl[6] <= ~pin_lvl[6];
        repeat (5) @(posedge pclk);
        chk(32'(block_irq), 32'h0000_0000);
        apb(1'b1, pci_pkg::IRQ_MASK_OFFSET, 32'h0000_0001);
        chk(32'(block_irq), 32'h0000_0001);
        apb(1'b0, pci_pkg::IRQ_STATUS_OFFSET, 32'h0000_0000);
        chk({block_irq, rd[30:0]}, 32'h0000_0001);
        // unmapped read, then a second reset
        apb(1'b0, 12'h100, 32'h0000_0000);
        chk({slv, rd[30:0]}, 32'h8000_0000);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (RST_ADDR[k]) begin
            apb(1'b0, RST_ADDR[k], 32'h0000_0000);
            chk(rd, 32'h0000_0000);
        end
        results();
    end
endmodule
